// >>> common/sfc_pkg.sv
// shared constants and types for the serial flash command and status block
package sfc_pkg;

  // command codes
  localparam logic [7:0] CMD_LATCH_SET  = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLR  = 8'h04;
  localparam logic [7:0] CMD_RD_STAT1   = 8'h05;
  localparam logic [7:0] CMD_RD_STAT2   = 8'h35;
  localparam logic [7:0] CMD_RD_STAT3   = 8'h15;
  localparam logic [7:0] CMD_WR_STAT1   = 8'h01;
  localparam logic [7:0] CMD_WR_STAT2   = 8'h31;
  localparam logic [7:0] CMD_WR_STAT3   = 8'h11;
  localparam logic [7:0] CMD_RD_DATA    = 8'h03;
  localparam logic [7:0] CMD_RD_FAST    = 8'h0b;
  localparam logic [7:0] CMD_RD_DUAL_O  = 8'h3b;
  localparam logic [7:0] CMD_RD_QUAD_O  = 8'h6b;
  localparam logic [7:0] CMD_RD_DUAL_IO = 8'hbb;
  localparam logic [7:0] CMD_RD_QUAD_IO = 8'heb;
  localparam logic [7:0] CMD_RD_MFR_ID  = 8'h90;
  localparam logic [7:0] CMD_RD_IDENT   = 8'h9f;
  localparam logic [7:0] CMD_RD_UNIQUE  = 8'h4b;
  localparam logic [7:0] CMD_RD_SEC     = 8'h48;
  localparam logic [7:0] CMD_RD_PARAM   = 8'h5a;
  localparam logic [7:0] CMD_PROG       = 8'h02;
  localparam logic [7:0] CMD_PROG_QUAD  = 8'h32;
  localparam logic [7:0] CMD_PROG_SEC   = 8'h42;
  localparam logic [7:0] CMD_ERASE_SECT = 8'h20;
  localparam logic [7:0] CMD_ERASE_32K  = 8'h52;
  localparam logic [7:0] CMD_ERASE_64K  = 8'hd8;
  localparam logic [7:0] CMD_ERASE_CH_A = 8'h60;
  localparam logic [7:0] CMD_ERASE_CH_B = 8'hc7;
  localparam logic [7:0] CMD_ERASE_SEC  = 8'h44;
  localparam logic [7:0] CMD_RST_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RST_DO     = 8'h99;
  localparam logic [7:0] CMD_SUSPEND    = 8'h75;
  localparam logic [7:0] CMD_RESUME     = 8'h7a;
  localparam logic [7:0] CMD_PD_ENTER   = 8'hb9;
  localparam logic [7:0] CMD_PD_RELEASE = 8'hab;

  // clock counts of the framing phases
  localparam logic [7:0] CMD_CLKS       = 8'h08;
  localparam logic [7:0] ADDR_CLKS      = 8'h18;
  localparam logic [7:0] BYTE_CLKS      = 8'h08;
  localparam logic [7:0] DUAL_ADDR_CLKS = 8'h0c;
  localparam logic [7:0] QUAD_ADDR_CLKS = 8'h06;
  localparam logic [7:0] DUMMY_DUAL_LO  = 8'h04;
  localparam logic [7:0] DUMMY_DUAL_HI  = 8'h08;
  localparam logic [7:0] DUMMY_QUAD_LO  = 8'h06;
  localparam logic [7:0] DUMMY_QUAD_HI  = 8'h0a;

  // status reset value and writable masks per status word
  localparam logic [23:0] ST_RESET  = 24'h200000;
  localparam logic [7:0]  ST1_WMASK = 8'hfc;
  localparam logic [7:0]  ST2_WMASK = 8'h7b;
  localparam logic [7:0]  ST3_WMASK = 8'h61;
  localparam logic [1:0]  GUARD_SW  = 2'h0;
  localparam logic [1:0]  GUARD_HW  = 2'h1;
  localparam logic [1:0]  GUARD_PSL = 2'h2;
  localparam logic [15:0] OP_CYCLES_DEF = 16'h0040;

  // status words three, two, one, most significant bit first
  typedef struct packed {
    logic       rsv_s23;
    logic [1:0] drive_strength;
    logic [3:0] rsv_s20_17;
    logic       latency_select;
    logic       erase_paused_flag;
    logic       protect_invert;
    logic       secreg_lock_c;
    logic       secreg_lock_b;
    logic       secreg_lock_a;
    logic       program_paused_flag;
    logic       quad_io_select;
    logic       sr_guard_hi;
    logic       sr_guard_lo;
    logic [4:0] protect_range_bits;
    logic       write_latch;
    logic       operation_busy;
  } sfc_status_t;

  // what the serial front end collected in the last frame
  typedef struct packed {
    logic [7:0]  cmd;
    logic [23:0] addr;
    logic [2:0]  nbytes;
    logic [2:0]  phase;
    logic [7:0]  clks;
    logic [6:0]  shift;
  } sfc_frame_t;

  typedef enum logic [1:0] {OP_IDLE, OP_RUN, OP_PAUSED} sfc_op_t;

endpackage

// >>> hdl/sfc_link.sv
// serial front end clocked by the host serial clock: bit capture and read data out
module sfc_link #(
  parameter logic [7:0] FILL_BYTE = 8'hff
) (
  input  wire logic                 sclk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 cs_n_i,
  input  wire logic [3:0]           io_i,
  input  wire sfc_pkg::sfc_status_t status_i,
  output sfc_pkg::sfc_frame_t       frame_o,
  output logic [3:0]                io_o,
  output logic [3:0]                io_oe_o
);
  logic                arst;
  logic                fresh_ff;
  sfc_pkg::sfc_frame_t q_ff;
  sfc_pkg::sfc_frame_t nxt_q;
  logic [7:0]          byte_in;
  logic                rd_en;
  logic [7:0]          rd_start;
  logic [1:0]          lanes;
  logic [7:0]          rd_byte;
  logic [2:0]          kb;
  logic [7:0]          sh;
  logic                go;
  logic [7:0]          out_ff;
  logic [7:0]          nxt_out;

  // deselect ends the frame without waiting for a clock that may never come
  assign arst = cs_n_i | ~rstn_i;

  // marks the first rising edge of a frame
  always_ff @(posedge sclk_i or posedge arst) begin
    if (arst) fresh_ff <= 1'b1;
    else fresh_ff <= 1'b0;
  end

  // bits shift in msb first, one per rising edge; bytes land by position
  always_comb begin
    nxt_q = q_ff;
    byte_in = {q_ff.shift, io_i[0]};
    if (fresh_ff) begin
      nxt_q.clks = 8'h01;
      nxt_q.phase = 3'h1;
      nxt_q.nbytes = 3'h0;
      nxt_q.shift = {6'h00, io_i[0]};
    end else begin
      if (q_ff.clks != 8'hff) nxt_q.clks = q_ff.clks + 8'h01;
      nxt_q.phase = q_ff.phase + 3'h1;
      nxt_q.shift = {q_ff.shift[5:0], io_i[0]};
      if (q_ff.phase == 3'h7) begin
        case (q_ff.nbytes)
          3'h0: nxt_q.cmd = byte_in;
          3'h1: nxt_q.addr[23:16] = byte_in;
          3'h2: nxt_q.addr[15:8] = byte_in;
          3'h3: nxt_q.addr[7:0] = byte_in;
          default: ;
        endcase
        if (q_ff.nbytes != 3'h7) nxt_q.nbytes = q_ff.nbytes + 3'h1;
      end
    end
  end

  // frame record holds still while deselected, which is when the core reads it
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) q_ff <= '0;
    else q_ff <= nxt_q;
  end

  // read kinds: where data starts and how many lanes carry it
  always_comb begin
    rd_en = 1'b1;
    lanes = 2'h0;
    rd_byte = FILL_BYTE;
    rd_start = sfc_pkg::CMD_CLKS + sfc_pkg::ADDR_CLKS + sfc_pkg::BYTE_CLKS;
    case (q_ff.cmd)
      sfc_pkg::CMD_RD_STAT1: begin
        rd_start = sfc_pkg::CMD_CLKS;
        rd_byte = status_i[7:0];
      end
      sfc_pkg::CMD_RD_STAT2: begin
        rd_start = sfc_pkg::CMD_CLKS;
        rd_byte = status_i[15:8];
      end
      sfc_pkg::CMD_RD_STAT3: begin
        rd_start = sfc_pkg::CMD_CLKS;
        rd_byte = status_i[23:16];
      end
      sfc_pkg::CMD_RD_IDENT: rd_start = sfc_pkg::CMD_CLKS;
      sfc_pkg::CMD_RD_DATA,
      sfc_pkg::CMD_RD_MFR_ID,
      sfc_pkg::CMD_PD_RELEASE: rd_start = sfc_pkg::CMD_CLKS + sfc_pkg::ADDR_CLKS;
      sfc_pkg::CMD_RD_FAST,
      sfc_pkg::CMD_RD_UNIQUE,
      sfc_pkg::CMD_RD_SEC,
      sfc_pkg::CMD_RD_PARAM: ;
      sfc_pkg::CMD_RD_DUAL_O: lanes = 2'h1;
      sfc_pkg::CMD_RD_QUAD_O: lanes = 2'h2;
      sfc_pkg::CMD_RD_DUAL_IO: begin
        lanes = 2'h1;
        rd_start = sfc_pkg::CMD_CLKS + sfc_pkg::DUAL_ADDR_CLKS + (status_i.latency_select ?
                   sfc_pkg::DUMMY_DUAL_HI : sfc_pkg::DUMMY_DUAL_LO);
      end
      sfc_pkg::CMD_RD_QUAD_IO: begin
        lanes = 2'h2;
        rd_start = sfc_pkg::CMD_CLKS + sfc_pkg::QUAD_ADDR_CLKS + (status_i.latency_select ?
                   sfc_pkg::DUMMY_QUAD_HI : sfc_pkg::DUMMY_QUAD_LO);
      end
      default: rd_en = 1'b0;
    endcase
  end

  // output bit position from the free phase counter, so reads may run on forever
  always_comb begin
    kb = q_ff.phase - rd_start[2:0];
    go = rd_en && (q_ff.nbytes != 3'h0) && (q_ff.clks >= rd_start);
    case (lanes)
      2'h1: sh = rd_byte << {kb[1:0], 1'b0};
      2'h2: sh = rd_byte << {kb[0], 2'b00};
      default: sh = rd_byte << kb;
    endcase
    nxt_out = out_ff;
    if (go) begin
      case (lanes)
        2'h1: nxt_out = {4'h3, 2'b00, sh[7:6]};
        2'h2: nxt_out = {4'hf, sh[7:4]};
        default: nxt_out = {4'h2, 2'b00, sh[7], 1'b0};
      endcase
    end
  end

  // data changes on the falling edge; deselect floats the lanes at once
  always_ff @(negedge sclk_i or posedge arst) begin
    if (arst) out_ff <= 8'h00;
    else out_ff <= nxt_out;
  end

  assign frame_o = q_ff;
  assign io_o    = out_ff[3:0];
  assign io_oe_o = out_ff[7:4];

endmodule

// >>> hdl/sfc_flash_ctl.sv
// serial flash command framing and status word control, core side
// Operation
// - guard pair at lock-down code returns to unprotected on a power cycle
// - quad select defaults 0 with protect pin active; 1 makes pins data lanes
// - three security lock bits default 0; each settable by status write
// - a set security lock bit never clears; that register becomes read-only
// - protection invert bit defaults 0, works with protect range bits; here both are only stored, no program or erase checks them
// - suspend sets erase-paused or program-paused flag per interrupted operation
// - resume, software reset pair and power cycle clear both paused flags
// - dual io read dummy clocks: 4 with latency select 0, 8 with 1
// - quad io read dummy clocks: 6 with latency select 0, 10 with 1
// - drive strength 00 full, 01 three quarters default, 10 half, 11 quarter
// - command bits msb first, one captured per rising clock after select falls
// - every frame starts with one command byte, then address and data
// - read commands drive data right after command, address and dummy clocks
// - host may end a read after any bit; device returns to deselected
// - modifying commands run only if frame clock count is a multiple of eight
// - partial byte ends a program: nothing programmed, write latch kept
// - latch set command sets write latch, needed before any modify command
// - latch clear command resets latch, ignored while busy
// - latch clears at power-up and when a modify operation completes
module sfc_flash_ctl #(
  parameter logic [15:0] OP_CYCLES = sfc_pkg::OP_CYCLES_DEF,
  parameter logic [7:0]  FILL_BYTE = 8'hff
) (
  input  wire logic          core_clk_i,
  input  wire logic          rstn_i,
  input  wire logic          ce_i,
  input  wire logic          pwr_cycle_i,
  input  wire logic          sclk_i,
  input  wire logic          cs_n_i,
  input  wire logic [3:0]    io_i,
  output logic [3:0]         io_o,
  output logic [3:0]         io_oe_o,
  output sfc_pkg::sfc_status_t status_o,
  output logic               deep_pd_o
);
  typedef struct packed {
    logic [2:0]           cs_sync;
    logic                 cs_hi;
    logic [2:0]           wp_sync;
    logic                 wp_hi;
    sfc_pkg::sfc_status_t st;
    sfc_pkg::sfc_op_t     op;
    logic                 erasing;
    logic                 stat_wr;
    logic [15:0]          cnt;
    logic                 rst_armed;
    logic                 deep_pd;
  } sfc_core_t;

  localparam sfc_core_t CORE_RST = '{
    cs_sync: 3'h7, cs_hi: 1'b1, wp_sync: 3'h7, wp_hi: 1'b1,
    st: sfc_pkg::sfc_status_t'(sfc_pkg::ST_RESET), op: sfc_pkg::OP_IDLE,
    erasing: 1'b0, stat_wr: 1'b0, cnt: 16'h0000, rst_armed: 1'b0, deep_pd: 1'b0};

  sfc_core_t           q_ff;
  sfc_core_t           nxt_q;
  sfc_pkg::sfc_frame_t f;
  logic                fe;
  logic                aligned;
  logic                wp_n;
  logic                guard_ok;
  logic                sec_ok;
  logic                can_mod;
  logic                start_op;
  logic                start_erase;
  logic                wr_st;
  logic [23:0]         w;
  logic [2:0]          locks;

  // serial clock domain; its frame record is read only once select is seen high
  sfc_link #(
    .FILL_BYTE (FILL_BYTE)
  ) u_link (
    .sclk_i   (sclk_i),
    .rstn_i   (rstn_i),
    .cs_n_i   (cs_n_i),
    .io_i     (io_i),
    .status_i (q_ff.st),
    .frame_o  (f),
    .io_o     (io_o),
    .io_oe_o  (io_oe_o)
  );

  // frame end: synced select agrees high on second and third stage
  assign fe      = ce_i & ~q_ff.cs_hi & q_ff.cs_sync[1] & q_ff.cs_sync[2];
  assign aligned = (f.phase == 3'h0) && (f.nbytes != 3'h0);
  assign locks   = {q_ff.st.secreg_lock_c, q_ff.st.secreg_lock_b, q_ff.st.secreg_lock_a};

  // protect pin exists only while the lane is not taken for quad data
  assign wp_n     = q_ff.st.quad_io_select | q_ff.wp_hi;
  assign guard_ok = ({q_ff.st.sr_guard_hi, q_ff.st.sr_guard_lo} == sfc_pkg::GUARD_SW) ||
                    (({q_ff.st.sr_guard_hi, q_ff.st.sr_guard_lo} == sfc_pkg::GUARD_HW) && wp_n);
  assign can_mod  = q_ff.st.write_latch && (q_ff.op == sfc_pkg::OP_IDLE);

  // security register picked by address; locked ones refuse program and erase
  always_comb begin
    case (f.addr[15:12])
      4'h1: sec_ok = ~locks[0];
      4'h2: sec_ok = ~locks[1];
      4'h3: sec_ok = ~locks[2];
      default: sec_ok = 1'b0;
    endcase
  end

  // next state of the whole core
  always_comb begin
    nxt_q = q_ff;
    start_op = 1'b0;
    start_erase = 1'b0;
    wr_st = 1'b0;
    w = q_ff.st;
    nxt_q.cs_sync = {q_ff.cs_sync[1:0], cs_n_i};
    if (q_ff.cs_sync[1] == q_ff.cs_sync[2]) nxt_q.cs_hi = q_ff.cs_sync[2];
    nxt_q.wp_sync = {q_ff.wp_sync[1:0], io_i[2]};
    if (q_ff.wp_sync[1] == q_ff.wp_sync[2]) nxt_q.wp_hi = q_ff.wp_sync[2];

    // completion waits for deselect so a status poll never sees a torn word
    if (q_ff.op == sfc_pkg::OP_RUN) begin
      if (q_ff.cnt != 16'h0000) begin
        nxt_q.cnt = q_ff.cnt - 16'h0001;
      end else if (q_ff.cs_hi) begin
        nxt_q.op = sfc_pkg::OP_IDLE;
        nxt_q.st.operation_busy = 1'b0;
        nxt_q.st.write_latch = 1'b0;
      end
    end

    // command decode at frame end; partial bytes fall through untouched
    if (fe && aligned && (!q_ff.deep_pd || f.cmd == sfc_pkg::CMD_PD_RELEASE)) begin
      nxt_q.rst_armed = (f.cmd == sfc_pkg::CMD_RST_ENABLE);
      case (f.cmd)
        sfc_pkg::CMD_LATCH_SET: nxt_q.st.write_latch = 1'b1;
        sfc_pkg::CMD_LATCH_CLR: begin
          if (q_ff.op != sfc_pkg::OP_RUN) nxt_q.st.write_latch = 1'b0;
        end
        sfc_pkg::CMD_WR_STAT1: begin
          if (can_mod && guard_ok && (f.nbytes == 3'h2 || f.nbytes == 3'h3)) begin
            wr_st = 1'b1;
            w[7:0] = (q_ff.st[7:0] & ~sfc_pkg::ST1_WMASK) | (f.addr[23:16] & sfc_pkg::ST1_WMASK);
            if (f.nbytes == 3'h3) begin
              w[15:8] = (q_ff.st[15:8] & ~sfc_pkg::ST2_WMASK) |
                        (f.addr[15:8] & sfc_pkg::ST2_WMASK);
            end
          end
        end
        sfc_pkg::CMD_WR_STAT2: begin
          if (can_mod && guard_ok && f.nbytes == 3'h2) begin
            wr_st = 1'b1;
            w[15:8] = (q_ff.st[15:8] & ~sfc_pkg::ST2_WMASK) |
                      (f.addr[23:16] & sfc_pkg::ST2_WMASK);
          end
        end
        sfc_pkg::CMD_WR_STAT3: begin
          if (can_mod && guard_ok && f.nbytes == 3'h2) begin
            wr_st = 1'b1;
            // reserved bits masked off, so a careless host cannot set them
            w[23:16] = (q_ff.st[23:16] & ~sfc_pkg::ST3_WMASK) |
                       (f.addr[23:16] & sfc_pkg::ST3_WMASK);
          end
        end
        sfc_pkg::CMD_PROG,
        sfc_pkg::CMD_PROG_QUAD: start_op = can_mod && (f.nbytes >= 3'h5);
        sfc_pkg::CMD_PROG_SEC: start_op = can_mod && sec_ok && (f.nbytes >= 3'h5);
        sfc_pkg::CMD_ERASE_SECT,
        sfc_pkg::CMD_ERASE_32K,
        sfc_pkg::CMD_ERASE_64K: begin
          start_op = can_mod && (f.nbytes == 3'h4);
          start_erase = 1'b1;
        end
        sfc_pkg::CMD_ERASE_SEC: begin
          start_op = can_mod && sec_ok && (f.nbytes == 3'h4);
          start_erase = 1'b1;
        end
        sfc_pkg::CMD_ERASE_CH_A,
        sfc_pkg::CMD_ERASE_CH_B: begin
          start_op = can_mod && (f.nbytes == 3'h1);
          start_erase = 1'b1;
        end
        sfc_pkg::CMD_SUSPEND: begin
          if (q_ff.op == sfc_pkg::OP_RUN && !q_ff.stat_wr) begin
            nxt_q.op = sfc_pkg::OP_PAUSED;
            nxt_q.st.operation_busy = 1'b0;
            if (q_ff.erasing) nxt_q.st.erase_paused_flag = 1'b1;
            else nxt_q.st.program_paused_flag = 1'b1;
          end
        end
        sfc_pkg::CMD_RESUME: begin
          if (q_ff.op == sfc_pkg::OP_PAUSED) begin
            nxt_q.op = sfc_pkg::OP_RUN;
            nxt_q.st.operation_busy = 1'b1;
            nxt_q.st.erase_paused_flag = 1'b0;
            nxt_q.st.program_paused_flag = 1'b0;
          end
        end
        sfc_pkg::CMD_RST_DO: begin
          if (q_ff.rst_armed) begin
            nxt_q.op = sfc_pkg::OP_IDLE;
            nxt_q.st.operation_busy = 1'b0;
            nxt_q.st.write_latch = 1'b0;
            nxt_q.st.erase_paused_flag = 1'b0;
            nxt_q.st.program_paused_flag = 1'b0;
          end
        end
        sfc_pkg::CMD_PD_ENTER: begin
          if (q_ff.op == sfc_pkg::OP_IDLE) nxt_q.deep_pd = 1'b1;
        end
        sfc_pkg::CMD_PD_RELEASE: nxt_q.deep_pd = 1'b0;
        default: ;
      endcase
    end

    // status write lands now; lock bits only ever accumulate
    if (wr_st) begin
      nxt_q.st = sfc_pkg::sfc_status_t'(w);
      nxt_q.st.secreg_lock_a = w[11] | locks[0];
      nxt_q.st.secreg_lock_b = w[12] | locks[1];
      nxt_q.st.secreg_lock_c = w[13] | locks[2];
      start_op = 1'b1;
    end
    if (start_op) begin
      nxt_q.op = sfc_pkg::OP_RUN;
      nxt_q.st.operation_busy = 1'b1;
      nxt_q.cnt = OP_CYCLES;
      nxt_q.erasing = start_erase;
      nxt_q.stat_wr = wr_st;
    end

    // power cycle keeps non-volatile fields, drops volatile ones
    if (pwr_cycle_i) begin
      nxt_q.op = sfc_pkg::OP_IDLE;
      nxt_q.deep_pd = 1'b0;
      nxt_q.rst_armed = 1'b0;
      nxt_q.st.operation_busy = 1'b0;
      nxt_q.st.write_latch = 1'b0;
      nxt_q.st.erase_paused_flag = 1'b0;
      nxt_q.st.program_paused_flag = 1'b0;
      if ({q_ff.st.sr_guard_hi, q_ff.st.sr_guard_lo} == sfc_pkg::GUARD_PSL) begin
        nxt_q.st.sr_guard_hi = 1'b0;
      end
    end
  end

  // single state register; clock enable freezes everything on this clock
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) q_ff <= CORE_RST;
    else if (ce_i) q_ff <= nxt_q;
  end

  assign status_o  = q_ff.st;
  assign deep_pd_o = q_ff.deep_pd;

  // checks on the core clock
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_end(logic [7:0] c);
    fe && aligned && (f.cmd == c) && !q_ff.deep_pd && !pwr_cycle_i;
  endsequence

  a_guard_power_clear: assert property (
    (ce_i && pwr_cycle_i && {q_ff.st.sr_guard_hi, q_ff.st.sr_guard_lo} == 2'h2)
    |=> ({q_ff.st.sr_guard_hi, q_ff.st.sr_guard_lo} == 2'h0))
    else $error("guard pair not cleared by power cycle");
  a_lock_otp_hold: assert property (
    1'b1 |=> (($past(locks) & ~locks) == 3'h0))
    else $error("security lock bit cleared");
  a_suspend_erase: assert property (
    s_end(sfc_pkg::CMD_SUSPEND) ##0 (q_ff.op == sfc_pkg::OP_RUN && q_ff.erasing && !q_ff.stat_wr)
    |=> (q_ff.st.erase_paused_flag && !q_ff.st.operation_busy))
    else $error("erase suspend did not set its flag");
  a_resume_clears: assert property (
    s_end(sfc_pkg::CMD_RESUME) ##0 (q_ff.op == sfc_pkg::OP_PAUSED)
    |=> (!q_ff.st.erase_paused_flag && !q_ff.st.program_paused_flag &&
         q_ff.st.operation_busy))
    else $error("resume left a paused flag set");
  a_latch_set: assert property (
    s_end(sfc_pkg::CMD_LATCH_SET) |=> q_ff.st.write_latch)
    else $error("latch set command ignored");
  a_clear_ignored_busy: assert property (
    s_end(sfc_pkg::CMD_LATCH_CLR) ##0 (q_ff.op == sfc_pkg::OP_RUN && q_ff.cnt != 16'h0000)
    |=> (q_ff.st.write_latch == $past(q_ff.st.write_latch)))
    else $error("latch cleared while busy");
  a_done_clears_latch: assert property (
    (ce_i && !pwr_cycle_i && q_ff.op == sfc_pkg::OP_RUN && q_ff.cnt == 16'h0000 && q_ff.cs_hi)
    |=> (!q_ff.st.write_latch && !q_ff.st.operation_busy && q_ff.op == sfc_pkg::OP_IDLE))
    else $error("completion left latch or busy set");
  a_partial_ignored: assert property (
    (fe && f.phase != 3'h0 && q_ff.op != sfc_pkg::OP_RUN && !pwr_cycle_i)
    |=> $stable(q_ff.st))
    else $error("partial-byte frame changed status");

endmodule

// >>> tb/sfc_host.sv
// host serial controller model that frames commands into the flash block
module sfc_host (
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic [3:0]      io_o,
  input  wire logic [3:0] dev_io_i,
  input  wire logic [3:0] dev_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drv;
  logic [7:0] rd;
  int         first_oe;
  // lane level: device wins where it drives, host elsewhere
  assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & drv);
  // clock idles low between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    drv = 4'h5;
  end
  // nb bits msb first on lane 0, nc clocks in all; idle lanes toggle
  task automatic xfer(input logic [63:0] d, input int nb, input int nc);
    first_oe = 0;
    cs_n_o = 1'b0;
    // select held low across two core edges, else the core never sees the frame
    #60;
    for (int i = 1; i <= nc; i++) begin
      drv = {~drv[3:1], (i <= nb) ? d[64-i] : ~drv[0]};
      #3 sclk_o = 1'b1;
      if (first_oe == 0 && dev_oe_i != 4'h0) first_oe = i;
      rd = {rd[6:0], io_o[1]};
      #3 sclk_o = 1'b0;
    end
    #2 cs_n_o = 1'b1;
    drv = ~drv;
    #400;
  endtask
endmodule

// >>> tb/test_serial_flash_cmd_status.sv
// testbench for the flash command framing and status control block
module test_serial_flash_cmd_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk;
  logic                 rstn;
  logic                 ce;
  logic                 pwr;
  logic                 sclk;
  logic                 cs_n;
  logic [3:0]           io_w;
  logic [3:0]           dio;
  logic [3:0]           doe;
  logic                 dpd;
  sfc_pkg::sfc_status_t st;
  int                   failures;
  int                   checked;
  logic [23:0]          dly [4] = '{24'h19, 24'h15, 24'h1d, 24'h19};

  sfc_flash_ctl #(.OP_CYCLES(16'h0030)) u_sfc_flash_ctl (
    .core_clk_i(core_clk), .rstn_i(rstn), .ce_i(ce), .pwr_cycle_i(pwr),
    .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_w), .io_o(dio), .io_oe_o(doe),
    .status_o(st), .deep_pd_o(dpd));
  sfc_host host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(io_w), .dev_io_i(dio), .dev_oe_i(doe));

  // core clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic stop_test();
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    host.xfer({c, 56'h0}, 8, 8);
  endtask

  task automatic rds(input logic [7:0] c, input logic [7:0] e);
    host.xfer({c, 56'h0}, 8, 16);
    chk("status byte", {16'h0, e}, {16'h0, host.rd});
  endtask

  // latch set, status write, then wait out the busy time
  task automatic wrs(input logic [23:0] v, input int nb);
    cmd(8'h06);
    host.xfer({v, 40'h0}, nb, nb);
    #3000;
  endtask

  // main sequence
  initial begin
    failures = 0;
    checked = 0;
    rstn = 1'b0;
    ce = 1'b1;
    pwr = 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("status reset", 24'h200000, st);
    cmd(8'h06);
    rds(8'h05, 8'h02);
    host.xfer({8'h04, 56'h0}, 9, 9);
    rds(8'h05, 8'h02);
    cmd(8'hff);
    rds(8'h05, 8'h02);
    cmd(8'h04);
    rds(8'h05, 8'h00);
    wrs({8'h31, 8'h3a, 8'h00}, 16);
    rds(8'h35, 8'h3a);
    rds(8'h05, 8'h00);
    wrs({8'h31, 8'h02, 8'h00}, 16);
    rds(8'h35, 8'h3a);
    // dummy length per latency select, output enable seen one edge later
    for (int j = 0; j < 2; j++) begin
      host.xfer({8'hbb, 56'h0}, 8, 40);
      chk("dual io dummy", dly[2*j], 24'(host.first_oe));
      host.xfer({8'heb, 56'h0}, 8, 40);
      chk("quad io dummy", dly[2*j+1], 24'(host.first_oe));
      wrs({8'h11, 8'h41, 8'h00}, 16);
    end
    rds(8'h15, 8'h41);
    cmd(8'h06);
    host.xfer({8'h02, 56'h0}, 39, 39);
    rds(8'h05, 8'h02);
    host.xfer({8'h02, 56'h0}, 40, 40);
    cmd(8'h75);
    rds(8'h35, 8'h3e);
    cmd(8'h7a);
    rds(8'h35, 8'h3a);
    #3000;
    rds(8'h05, 8'h00);
    cmd(8'h06);
    host.xfer({8'h20, 56'h0}, 32, 32);
    cmd(8'h04);
    rds(8'h05, 8'h03);
    cmd(8'h75);
    rds(8'h35, 8'hba);
    cmd(8'h66);
    cmd(8'h99);
    rds(8'h35, 8'h3a);
    #3000;
    wrs({8'h01, 8'h00, 8'h3b}, 24);
    rds(8'h35, 8'h3b);
    cmd(8'h06);
    @(posedge core_clk) pwr <= 1'b1;
    @(posedge core_clk) pwr <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("status after power cycle", 24'h413a00, st);
    cmd(8'h06);
    chk("latch after set", 24'h413a02, st);
    // a power pulse while the core is frozen must leave no trace
    @(posedge core_clk) ce <= 1'b0;
    @(posedge core_clk) pwr <= 1'b1;
    @(posedge core_clk) pwr <= 1'b0;
    @(posedge core_clk) ce <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("frozen power cycle", 24'h413a02, st);
    // deep power-down: the core obeys only the release command, status reads still answer
    cmd(8'hb9);
    chk("deep power-down entry", 24'h000001, 24'(dpd));
    cmd(8'h04);
    rds(8'h05, 8'h02);
    cmd(8'hab);
    chk("deep power-down release", 24'h000000, 24'(dpd));
    stop_test();
  end

  // watchdog well beyond the expected run of about 50 us
  initial begin
    #300us;
    failures++;
    stop_test();
  end
endmodule
